// ---- logic/asp_pkg.sv ----
// Purpose: shared constants and carriers for the async serial port
// Assumes: 32-bit axi4-lite register access, one clock
// Notes:   all offsets are byte addresses of aligned words
package asp_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] DIV_OFF    = 8'h04;
  localparam logic [7:0] TXD_OFF    = 8'h08;
  localparam logic [7:0] RXD_OFF    = 8'h0c;
  localparam logic [7:0] STAT_OFF   = 8'h10;
  localparam logic [7:0] IRQ_OFF    = 8'h14;
  localparam logic [7:0] MASK_OFF   = 8'h18;
  // ==========================================================
  // reset values and field positions
  localparam logic [15:0] DIV_RST   = 16'h0001;
  localparam logic [9:0]  CTRL_RST  = 10'h003;
  localparam int          IRQ_TX    = 0;
  localparam int          IRQ_RX    = 1;
  localparam int          IRQ_PAR   = 2;
  localparam int          IRQ_FRM   = 3;
  localparam int          IRQ_OVR   = 4;
  localparam int          IRQ_ADR   = 5;
  localparam int          OVS       = 16;
  localparam logic [3:0]  OVS_LAST  = 4'hf;
  localparam logic [3:0]  OVS_MID   = 4'h7;
  localparam logic [1:0]  AXI_OKAY  = 2'h0;
  localparam logic [1:0]  AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_EVEN = 2'h1,
    PAR_ODD  = 2'h2
  } asp_par_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h2,
    ST_PAR   = 3'h3,
    ST_STOP  = 3'h4
  } asp_state_t;

  // control register: frame format and modes
  typedef struct packed {
    logic       err_en;    // 9: error codes into rx word
    logic       dma_en;    // 8
    logic       addr_mode; // 7: 9-bit multidrop
    logic       stop2;     // 6
    asp_par_t   par;       // 5:4
    logic [1:0] len;       // 3:2, bits = 5 + len
    logic       rx_en;     // 1
    logic       tx_en;     // 0
  } asp_ctrl_t;
endpackage

// ---- logic/asp_top.sv ----
// Purpose: full-duplex async serial port with axi4-lite registers and dma
// Assumes: clk_i at 200 MHz, rx_i from a pin, dma handshakes on clk_i
// Notes:   bit time is 16 x divisor clocks; frame of 7 to 12 bits
// Notes on behaviour
// (RULE1) transmit and receive run at the same time with separate logic.
// (RULE2) a 9-bit mode sends an address flag as ninth bit and filters receive.
// (RULE3) data length is five to eight bits.
// (RULE4) one or two stop bits are sent and checked.
// (RULE5) parity none, even or odd is made on transmit and checked on receive.
// (RULE6) software moves characters by register writes and reads.
// (RULE7) a holding register sits before the tx shifter and after the rx shifter.
// (RULE8) one dma request pair serves transmit and another receive.
// (RULE9) the dma controller gives these channels low priority.
// (RULE10) bit rate spans pclk/1048576 to pclk/16.
// (RULE11) a frame holds seven to twelve bits in all.
// (RULE12) tx and rx events raise maskable interrupts.
// (RULE13) receive errors show as status and optionally as codes in the word.
// (RULE14) an outside timer measures rx for autobaud; rx level is exported.
// (RULE15) bit clock is pclk over sixteen times a 16-bit divisor.
// (RULE16) low start, lsb first data, parity, high stops; idle high.
module asp_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // axi4-lite slave
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  // dma channels
  output logic             dma_tx_req_o,
  input  wire logic [8:0]  dma_tx_data_i,
  input  wire logic        dma_tx_ack_i,
  output logic             dma_rx_req_o,
  output logic [15:0]      dma_rx_data_o,
  input  wire logic        dma_rx_ack_i,
  // serial line and interrupt
  input  wire logic        rx_i,
  output logic             tx_o,
  output logic             rx_sync_o,
  output logic             irq_o
);
  // ==========================================================
  // registers
  asp_pkg::asp_ctrl_t ctrl_r;
  logic [15:0]        div_r;
  logic [5:0]         irq_r, mask_r;
  logic [8:0]         thr_r;
  logic               thr_full_r;
  logic [15:0]        rhr_r;
  logic               rhr_full_r;
  logic [3:0]         nbits;
  logic               aw_ok, ar_ok, wr_fire, rd_fire;
  logic               txd_wr, rxd_rd;
  logic [5:0]         ev, w1c;
  logic               sy1_r, sy2_r;

  assign nbits = 4'h5 + {2'h0, ctrl_r.len};                // RULE3 RULE11
  // assertions below share this clock and reset
  default clocking asp_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // axi4-lite write: take address and data together, then respond
  assign aw_ok     = awvalid_i && wvalid_i && !bvalid_o;
  assign awready_o = aw_ok;
  assign wready_o  = aw_ok;
  assign wr_fire   = aw_ok;
  assign txd_wr    = wr_fire && awaddr_i == asp_pkg::TXD_OFF && wstrb_i[0]; // RULE6
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_o <= 1'b0;
      bresp_o  <= asp_pkg::AXI_OKAY;
    end else if (wr_fire) begin
      bvalid_o <= 1'b1;
      bresp_o  <= (awaddr_i <= asp_pkg::MASK_OFF && awaddr_i[1:0] == 2'h0 &&
                   awaddr_i != asp_pkg::RXD_OFF && awaddr_i != asp_pkg::STAT_OFF)
                  ? asp_pkg::AXI_OKAY : asp_pkg::AXI_SLVERR;
    end else if (bready_i) begin
      bvalid_o <= 1'b0;
    end
  end

  wr_answer_a: assert property (wr_fire |=> bvalid_o) // RULE6
    else $error("write taken without a response");

  // config registers, byte lanes honoured
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= asp_pkg::asp_ctrl_t'(asp_pkg::CTRL_RST);
      div_r  <= asp_pkg::DIV_RST;
      mask_r <= 6'h00;
    end else if (wr_fire) begin
      if (awaddr_i == asp_pkg::CTRL_OFF) begin
        if (wstrb_i[0]) ctrl_r[7:0] <= wdata_i[7:0];
        if (wstrb_i[1]) ctrl_r[9:8] <= wdata_i[9:8];
      end
      if (awaddr_i == asp_pkg::DIV_OFF) begin                  // RULE10 RULE15
        if (wstrb_i[0]) div_r[7:0]  <= wdata_i[7:0];
        if (wstrb_i[1]) div_r[15:8] <= wdata_i[15:8];
      end
      if (awaddr_i == asp_pkg::MASK_OFF && wstrb_i[0]) mask_r <= wdata_i[5:0]; // RULE12
    end
  end

  // ==========================================================
  // axi4-lite read
  assign ar_ok     = arvalid_i && !rvalid_o;
  assign arready_o = ar_ok;
  assign rd_fire   = ar_ok;
  assign rxd_rd    = rd_fire && araddr_i == asp_pkg::RXD_OFF;  // RULE6
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= 32'h0;
      rresp_o  <= asp_pkg::AXI_OKAY;
    end else if (rd_fire) begin
      rvalid_o <= 1'b1;
      rresp_o  <= asp_pkg::AXI_OKAY;
      case (araddr_i)
        asp_pkg::CTRL_OFF: rdata_o <= {22'h0, ctrl_r};
        asp_pkg::DIV_OFF:  rdata_o <= {16'h0, div_r};
        asp_pkg::TXD_OFF:  rdata_o <= {23'h0, thr_r};
        asp_pkg::RXD_OFF:  rdata_o <= {16'h0, rhr_r};
        asp_pkg::STAT_OFF: rdata_o <= {28'h0, sy2_r, rhr_full_r, thr_full_r, 1'b0}; // RULE13
        asp_pkg::IRQ_OFF:  rdata_o <= {26'h0, irq_r};
        asp_pkg::MASK_OFF: rdata_o <= {26'h0, mask_r};
        default: begin
          rdata_o <= 32'h0;
          rresp_o <= asp_pkg::AXI_SLVERR;
        end
      endcase
    end else if (rready_i) begin
      rvalid_o <= 1'b0;
    end
  end

  rd_answer_a: assert property (rd_fire |=> rvalid_o) // RULE6
    else $error("read taken without data");

  // ==========================================================
  // rx pin synchroniser; the level also feeds an outside timer for autobaud
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sy1_r <= 1'b1;
      sy2_r <= 1'b1;
    end else begin
      sy1_r <= rx_i;
      sy2_r <= sy1_r;
    end
  end
  assign rx_sync_o = sy2_r;                                    // RULE14

  // ==========================================================
  // transmitter: holding register then shifter
  asp_pkg::asp_state_t tst_r;
  logic [15:0] tdiv_r;
  logic [3:0]  tovs_r, tcnt_r;
  logic [8:0]  tsh_r;
  logic        tpar_r, ttick, tload, tdone, tstop2_r;
  assign ttick = tdiv_r == 16'h0;
  assign tload = tst_r == asp_pkg::ST_IDLE && thr_full_r && ctrl_r.tx_en;
  assign dma_tx_req_o = ctrl_r.dma_en && !thr_full_r;          // RULE8

  // holding register fills from bus or dma, empties into the shifter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_r      <= 9'h0;
      thr_full_r <= 1'b0;
    end else if (txd_wr && !thr_full_r) begin                  // RULE7
      thr_r      <= wdata_i[8:0];
      thr_full_r <= 1'b1;
    end else if (dma_tx_req_o && dma_tx_ack_i) begin           // RULE8
      thr_r      <= dma_tx_data_i;
      thr_full_r <= 1'b1;
    end else if (tload) begin
      thr_full_r <= 1'b0;
    end
  end

  dma_take_a: assert property (dma_tx_req_o && dma_tx_ack_i && !txd_wr |=> // RULE8
                               thr_full_r && thr_r == $past(dma_tx_data_i))
    else $error("dma word not taken into the holding register");

  // bit timer: div x 16 clocks per bit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tst_r    <= asp_pkg::ST_IDLE;
      tdiv_r   <= 16'h0;
      tovs_r   <= 4'h0;
      tcnt_r   <= 4'h0;
      tsh_r    <= 9'h0;
      tpar_r   <= 1'b0;
      tstop2_r <= 1'b0;
      tx_o     <= 1'b1;
    end else begin
      tdiv_r <= ttick ? div_r - 16'h1 : tdiv_r - 16'h1;        // RULE15
      if (tload) begin
        tst_r    <= asp_pkg::ST_START;
        tsh_r    <= thr_r;
        tpar_r   <= ctrl_r.par == asp_pkg::PAR_ODD;
        tstop2_r <= ctrl_r.stop2;
        tovs_r   <= 4'h0;
        tdiv_r   <= div_r - 16'h1;
        tx_o     <= 1'b0;                                      // RULE16
      end else if (ttick && tst_r != asp_pkg::ST_IDLE) begin
        tovs_r <= tovs_r + 4'h1;
        if (tovs_r == asp_pkg::OVS_LAST) begin
          case (tst_r)
            asp_pkg::ST_START: begin
              tst_r  <= asp_pkg::ST_DATA;
              tcnt_r <= 4'h0;
              tx_o   <= tsh_r[0];
            end
            asp_pkg::ST_DATA: begin
              tpar_r <= tpar_r ^ tsh_r[0];                     // RULE5
              tsh_r  <= {tsh_r[8], 1'b0, tsh_r[7:1]};        // flag bit stays put
              tcnt_r <= tcnt_r + 4'h1;
              if (tcnt_r + 4'h1 == nbits && ctrl_r.addr_mode) begin
                tst_r <= asp_pkg::ST_PAR;                      // RULE2
                tx_o  <= tsh_r[8];
              end else if (tcnt_r + 4'h1 == nbits && ctrl_r.par != asp_pkg::PAR_NONE) begin
                tst_r <= asp_pkg::ST_PAR;
                tx_o  <= tpar_r ^ tsh_r[0];
              end else if (tcnt_r + 4'h1 == nbits) begin
                tst_r  <= asp_pkg::ST_STOP;
                tcnt_r <= 4'h0;
                tx_o   <= 1'b1;
              end else begin
                tx_o <= tsh_r[1];                              // RULE16
              end
            end
            asp_pkg::ST_PAR: begin
              tst_r  <= asp_pkg::ST_STOP;
              tcnt_r <= 4'h0;
              tx_o   <= 1'b1;
            end
            asp_pkg::ST_STOP: begin                            // RULE4
              tcnt_r <= tcnt_r + 4'h1;
              if (!tstop2_r || tcnt_r == 4'h1) tst_r <= asp_pkg::ST_IDLE;
            end
            default: tst_r <= asp_pkg::ST_IDLE;
          endcase
        end
      end
    end
  end
  assign tdone = ttick && tovs_r == asp_pkg::OVS_LAST && tst_r == asp_pkg::ST_STOP &&
                 (!tstop2_r || tcnt_r == 4'h1);
  // frame end leaves the line at rest; a load drives the start bit at once
  sequence tx_end_s; tdone; endsequence
  sequence tx_rest_s; tx_o && tst_r == asp_pkg::ST_IDLE; endsequence
  stop_rest_a: assert property (tx_end_s |=> tx_rest_s) // RULE4
    else $error("line not at rest after the last stop bit");
  start_bit_a: assert property (tload |=> !tx_o && tst_r == asp_pkg::ST_START) // RULE16
    else $error("start bit not driven low");

  // ==========================================================
  // receiver: independent of the transmitter
  asp_pkg::asp_state_t rst_st_r;
  logic [15:0] rdiv_r;
  logic [3:0]  rovs_r, rcnt_r;
  logic [8:0]  rsh_r;
  logic        rpar_r, rtick, rsamp, rdone, rperr_r, rferr, radr_ok;
  assign rtick = rdiv_r == 16'h0;
  assign rsamp = rtick && rovs_r == asp_pkg::OVS_MID;          // sample mid bit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_st_r <= asp_pkg::ST_IDLE;
      rdiv_r   <= 16'h0;
      rovs_r   <= 4'h0;
      rcnt_r   <= 4'h0;
      rsh_r    <= 9'h0;
      rpar_r   <= 1'b0;
      rperr_r  <= 1'b0;
    end else begin
      rdiv_r <= rtick ? div_r - 16'h1 : rdiv_r - 16'h1;
      if (rst_st_r == asp_pkg::ST_IDLE) begin
        rovs_r <= 4'h0;
        if (!sy2_r && ctrl_r.rx_en) begin                      // RULE16
          rst_st_r <= asp_pkg::ST_START;
          rdiv_r   <= div_r - 16'h1;
          rpar_r   <= ctrl_r.par == asp_pkg::PAR_ODD;
          rperr_r  <= 1'b0;
          rsh_r    <= 9'h0;
        end
      end else if (rtick) begin
        rovs_r <= rovs_r + 4'h1;
        if (rsamp) begin
          case (rst_st_r)
            asp_pkg::ST_START: begin
              rcnt_r   <= 4'h0;
              rst_st_r <= sy2_r ? asp_pkg::ST_IDLE : asp_pkg::ST_DATA; // glitch rejected
            end
            asp_pkg::ST_DATA: begin
              rsh_r[rcnt_r] <= sy2_r;                          // lsb first
              rpar_r <= rpar_r ^ sy2_r;                        // RULE5
              rcnt_r <= rcnt_r + 4'h1;
              if (rcnt_r + 4'h1 == nbits)
                rst_st_r <= (ctrl_r.addr_mode || ctrl_r.par != asp_pkg::PAR_NONE) ?
                            asp_pkg::ST_PAR : asp_pkg::ST_STOP;
            end
            asp_pkg::ST_PAR: begin
              if (ctrl_r.addr_mode) rsh_r[8] <= sy2_r;         // RULE2
              else rperr_r <= rpar_r ^ sy2_r;
              rst_st_r <= asp_pkg::ST_STOP;
              rcnt_r   <= 4'h0;
            end
            asp_pkg::ST_STOP: begin                            // RULE4
              rcnt_r <= rcnt_r + 4'h1;
              if (!ctrl_r.stop2 || rcnt_r == 4'h1 || !sy2_r) rst_st_r <= asp_pkg::ST_IDLE;
            end
            default: rst_st_r <= asp_pkg::ST_IDLE;
          endcase
        end
      end
    end
  end
  assign rdone = rsamp && rst_st_r == asp_pkg::ST_STOP &&
                 (!ctrl_r.stop2 || rcnt_r == 4'h1 || !sy2_r);
  assign rferr = !sy2_r;                                       // RULE13
  // in 9-bit mode only address characters pass until the first one arrives; then all pass
  logic adr_seen_r;
  assign radr_ok = !ctrl_r.addr_mode || rsh_r[8] || adr_seen_r; // RULE2
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) adr_seen_r <= 1'b0;
    else if (rdone && ctrl_r.addr_mode && rsh_r[8]) adr_seen_r <= 1'b1;
  end

  // receive holding register; word = err codes 11:9, data 8:0
  assign dma_rx_req_o  = ctrl_r.dma_en && rhr_full_r;          // RULE8
  assign dma_rx_data_o = rhr_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rhr_r      <= 16'h0;
      rhr_full_r <= 1'b0;
    end else if (rdone && radr_ok) begin                       // RULE7
      rhr_r      <= {4'h0, ctrl_r.err_en & (rhr_full_r & !rxd_rd),
                     ctrl_r.err_en & rferr, ctrl_r.err_en & rperr_r, rsh_r}; // RULE13
      rhr_full_r <= 1'b1;
    end else if (rxd_rd || (dma_rx_req_o && dma_rx_ack_i)) begin
      rhr_full_r <= 1'b0;
    end
  end

  rx_hold_a: assert property (rdone && radr_ok |=> rhr_full_r) // RULE7
    else $error("received character not held");

  // ==========================================================
  // sticky events, write one to clear; a new event beats its clear
  assign ev = {rdone & ctrl_r.addr_mode & rsh_r[8], rdone & radr_ok & rhr_full_r,
               rdone & rferr, rdone & rperr_r, rdone & radr_ok, tdone};
  assign w1c = (wr_fire && awaddr_i == asp_pkg::IRQ_OFF && wstrb_i[0]) ? wdata_i[5:0] : 6'h0;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) irq_r <= 6'h00;
    else irq_r <= (irq_r & ~w1c) | ev;                         // RULE12 RULE13
  end
  assign irq_o = |(irq_r & mask_r);                            // RULE12
  irq_sticky_a: assert property ((|ev) |=> (irq_r & $past(ev)) == $past(ev)) // RULE12
    else $error("event lost against its clear");
  // RULE1 RULE9: transmit and receive share only the divisor, the frame format fields and dma_en; dma priority is outside
endmodule

// ---- test/asp_remote.sv ----
// Purpose: remote serial peer that frames characters onto rx and checks frames from tx
// Assumes: bench sets bit_clk and the format fields while the line is idle
// Notes:   receive samples mid-bit; gap is clk_i cycles between two start edges
module asp_remote (
  // clock
  input  wire logic clk_i,
  // serial lines
  input  wire logic line_i,
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bit_clk = 16;
  int         nbits   = 5;
  int         par     = 0;
  bit         nine    = 0;
  int         stops   = 1;
  logic [8:0] got     = '0;
  logic [8:0] prev    = '0;
  logic       par_got = 1'b0;
  logic       stop_ok = 1'b0;
  int         frames  = 0;
  int         cyc     = 0;
  int         t_last  = 0;
  int         gap     = 0;

  // ==========================================================
  // helpers
  // free cycle count, used to measure the spacing of frames
  always @(posedge clk_i) cyc++;

  function automatic logic pbit(input logic [8:0] d);
    logic [7:0] m;
    m = 8'hff >> (8 - nbits);
    return (par == 1) ? ^(d[7:0] & m) : ~^(d[7:0] & m);
  endfunction

  // ==========================================================
  // transmit toward the port; line rests at mark level between frames
  initial line_o = 1'b1;
  task automatic send(input logic [8:0] d, input logic bad_par, input logic bad_stop);
    line_o <= 1'b0;
    repeat (bit_clk) @(posedge clk_i);
    for (int i = 0; i < nbits; i++) begin
      line_o <= d[i];
      repeat (bit_clk) @(posedge clk_i);
    end
    if (nine || par != 0) begin
      line_o <= (nine ? d[8] : pbit(d)) ^ bad_par;
      repeat (bit_clk) @(posedge clk_i);
    end
    for (int s = 0; s < stops; s++) begin
      line_o <= !(bad_stop && s == 0);
      repeat (bit_clk) @(posedge clk_i);
    end
    line_o <= 1'b1;
    @(posedge clk_i);
  endtask

  // ==========================================================
  // receive from the port; a late edge is caught by the gap figure
  initial forever begin
    @(negedge line_i);
    gap = cyc - t_last;
    t_last = cyc;
    repeat (bit_clk / 2) @(posedge clk_i);
    prev = got;
    got = '0;
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_clk) @(posedge clk_i);
      got[i] = line_i;
    end
    if (nine || par != 0) begin
      repeat (bit_clk) @(posedge clk_i);
      par_got = line_i;
    end
    if (nine) got[8] = par_got;
    stop_ok = 1'b1;
    for (int s = 0; s < stops; s++) begin
      repeat (bit_clk) @(posedge clk_i);
      stop_ok &= line_i;
    end
    frames++;
  end
endmodule

// ---- test/test_async_serial_port.sv ----
// Purpose: register-level bench for the async serial port
// Assumes: DIV reset value gives 16 clocks a bit; bus tasks entered after a rising edge
// Notes:   expected frames and codes are worked out here from the format fields
module test_async_serial_port;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH at %0t: got %h expected %h", $time, (a), (e)); end end
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [8:0]  dma_tx_data = '0;
  logic        dma_tx_ack = 0, dma_rx_ack = 0, dma_tx_req, dma_rx_req;
  logic [15:0] dma_rx_data;
  logic        rx_line, tx_line, rx_sync, irq;
  int          failures = 0;
  int          total_checks = 0;

  // ==========================================================
  // clock, device and far side
  initial forever #2.5 clk_i = ~clk_i;
  asp_top dut (.clk_i(clk_i), .rst_i(rst_i), .awaddr_i(awaddr), .awvalid_i(awvalid),
    .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hf), .wvalid_i(wvalid),
    .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
    .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready), .dma_tx_req_o(dma_tx_req),
    .dma_tx_data_i(dma_tx_data), .dma_tx_ack_i(dma_tx_ack), .dma_rx_req_o(dma_rx_req),
    .dma_rx_data_o(dma_rx_data), .dma_rx_ack_i(dma_rx_ack), .rx_i(rx_line),
    .tx_o(tx_line), .rx_sync_o(rx_sync), .irq_o(irq));
  asp_remote u_rem (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));

  // ==========================================================
  // closing, timeouts and bus tasks
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tmo(input bit bad);
    if (bad) begin
      failures++;
      $display("MISMATCH at %0t: wait ran out", $time);
      close_out();
    end
  endtask
  // both write channels offered together; response accepted before release
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    n = 0;
    do begin @(negedge clk_i); n++; end while ((awready & wready) !== 1'b1 && n < 200);
    tmo(n >= 200);
    @(posedge clk_i);
    awvalid <= 1'b0; wvalid <= 1'b0;
    n = 0;
    do begin @(negedge clk_i); n++; end while (bvalid !== 1'b1 && n < 200);
    tmo(n >= 200);
    `CHK(bresp, er)
    @(posedge clk_i);
    bready <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    n = 0;
    do begin @(negedge clk_i); n++; end while (arready !== 1'b1 && n < 200);
    tmo(n >= 200);
    @(posedge clk_i);
    arvalid <= 1'b0;
    n = 0;
    do begin @(negedge clk_i); n++; end while (rvalid !== 1'b1 && n < 200);
    tmo(n >= 200);
    d = rdata;
    `CHK(rresp, er)
    @(posedge clk_i);
    rready <= 1'b0;
    @(posedge clk_i);
  endtask
  // frame format into the port and the far side alike
  task automatic fmt(input logic [1:0] l, p, input logic s2, nn, dm, er);
    wr(asp_pkg::CTRL_OFF, {22'h0, er, dm, nn, s2, p, l, 2'b11});
    u_rem.nbits = 5 + l; u_rem.par = p; u_rem.nine = nn; u_rem.stops = 1 + s2;
  endtask
  task automatic wait_fr(input int n);
    int k;
    for (k = 0; k < 20000 && u_rem.frames < n; k++) @(posedge clk_i);
    tmo(k >= 20000);
  endtask
  task automatic wait_rx();
    logic [31:0] s;
    int k;
    for (k = 0; k < 100; k++) begin
      rd(asp_pkg::STAT_OFF, s);
      if (s[2] === 1'b1) break;
    end
    tmo(k >= 100);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [7:0]  m;
    logic [1:0]  l, p;
    logic        s2;
    int          f, nb;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values and refused accesses
    rd(asp_pkg::CTRL_OFF, d); `CHK(d, {22'h0, asp_pkg::CTRL_RST})
    rd(asp_pkg::DIV_OFF, d); `CHK(d, {16'h0, asp_pkg::DIV_RST})
    rd(asp_pkg::MASK_OFF, d); `CHK(d, 32'h0)
    rd(asp_pkg::IRQ_OFF, d); `CHK(d, 32'h0)
    rd(asp_pkg::STAT_OFF, d); `CHK(d, 32'h8)
    rd(8'h1c, d, asp_pkg::AXI_SLVERR); `CHK(d, 32'h0)
    wr(asp_pkg::STAT_OFF, 32'h1, asp_pkg::AXI_SLVERR);
    wr(asp_pkg::RXD_OFF, 32'h1, asp_pkg::AXI_SLVERR);
    `CHK({tx_line, rx_sync, irq}, 3'b110)
    // every length, parity and stop choice; two characters back to back
    for (int i = 0; i < 24; i++) begin
      l = 2'(i % 4); p = 2'((i / 4) % 3); s2 = 1'(i / 12);
      fmt(l, p, s2, 0, 0, 1);
      f = u_rem.frames;
      wr(asp_pkg::TXD_OFF, 32'h3c ^ i);
      wr(asp_pkg::TXD_OFF, 32'ha5 ^ i);
      wait_fr(f + 2);
      m = 8'hff >> (3 - l);
      nb = 7 + l + (p != 0) + s2;
      `CHK(u_rem.prev, {1'b0, 8'(8'h3c ^ i) & m})
      `CHK(u_rem.got, {1'b0, 8'(8'ha5 ^ i) & m})
      `CHK(u_rem.stop_ok, 1'b1)
      if (p != 0) `CHK(u_rem.par_got, u_rem.pbit(9'(8'ha5 ^ i)))
      `CHK(u_rem.gap >= nb * 16 && u_rem.gap <= nb * 16 + 3, 1'b1)
      repeat (16) @(posedge clk_i);
    end
    // slower divisor: bit time follows sixteen times the divisor
    wr(asp_pkg::DIV_OFF, 32'h2);
    u_rem.bit_clk = 32;
    fmt(3, 0, 0, 0, 0, 1);
    f = u_rem.frames;
    wr(asp_pkg::TXD_OFF, 32'h11);
    wr(asp_pkg::TXD_OFF, 32'h22);
    wait_fr(f + 2);
    `CHK(u_rem.gap >= 320 && u_rem.gap <= 323, 1'b1)
    repeat (32) @(posedge clk_i);
    wr(asp_pkg::DIV_OFF, 32'h1);
    u_rem.bit_clk = 16;
    // receive, interrupt and error codes with even parity
    fmt(3, 1, 0, 0, 0, 1);
    wr(asp_pkg::MASK_OFF, 32'h1 << asp_pkg::IRQ_RX);
    u_rem.send(9'h0a5, 0, 0);
    wait_rx();
    `CHK(irq, 1'b1)
    rd(asp_pkg::RXD_OFF, d); `CHK(d, 32'h0a5)
    wr(asp_pkg::IRQ_OFF, 32'h3f);
    `CHK(irq, 1'b0)
    u_rem.send(9'h033, 1, 0);
    wait_rx();
    rd(asp_pkg::RXD_OFF, d); `CHK(d, 32'h233)
    u_rem.send(9'h044, 0, 1);
    repeat (32) @(posedge clk_i);
    wait_rx();
    rd(asp_pkg::RXD_OFF, d); `CHK(d, 32'h444)
    u_rem.send(9'h011, 0, 0);
    u_rem.send(9'h022, 0, 0);
    wait_rx();
    rd(asp_pkg::RXD_OFF, d); `CHK(d, 32'h822)
    rd(asp_pkg::IRQ_OFF, d); `CHK(d[5:1], 5'h0f)
    // codes off: status still raised, word clean, interrupt masked
    fmt(3, 1, 0, 0, 0, 0);
    wr(asp_pkg::MASK_OFF, 32'h0);
    u_rem.send(9'h055, 1, 0);
    wait_rx();
    `CHK(irq, 1'b0)
    rd(asp_pkg::RXD_OFF, d); `CHK(d, 32'h055)
    // both directions at once
    fmt(3, 0, 0, 0, 0, 1);
    f = u_rem.frames;
    fork
      u_rem.send(9'h0c3, 0, 0);
      wr(asp_pkg::TXD_OFF, 32'h3a);
      begin repeat (8) @(posedge clk_i); `CHK(rx_sync, 1'b0) end
    join
    wait_fr(f + 1);
    `CHK(u_rem.got, 9'h03a)
    wait_rx();
    rd(asp_pkg::RXD_OFF, d); `CHK(d, 32'h0c3)
    // dma: one transmit request and one receive request, each acked at once
    fmt(3, 0, 0, 0, 1, 1);
    f = u_rem.frames;
    @(negedge clk_i); `CHK(dma_tx_req, 1'b1)
    @(posedge clk_i);
    dma_tx_data <= 9'h05e; dma_tx_ack <= 1'b1;
    @(posedge clk_i);
    dma_tx_ack <= 1'b0;
    wait_fr(f + 1);
    `CHK(u_rem.got, 9'h05e)
    u_rem.send(9'h06b, 0, 0);
    for (f = 0; f < 200 && dma_rx_req !== 1'b1; f++) @(negedge clk_i);
    tmo(f >= 200);
    `CHK(dma_rx_data[8:0], 9'h06b)
    @(posedge clk_i);
    dma_rx_ack <= 1'b1;
    @(posedge clk_i);
    dma_rx_ack <= 1'b0;
    @(negedge clk_i); `CHK(dma_rx_req, 1'b0)
    @(posedge clk_i);
    // nine-bit mode: filtered until an address character arrives
    fmt(3, 0, 0, 1, 0, 1);
    u_rem.send(9'h042, 0, 0);
    repeat (40) @(posedge clk_i);
    rd(asp_pkg::STAT_OFF, d); `CHK(d[2], 1'b0)
    u_rem.send(9'h13c, 0, 0);
    wait_rx();
    rd(asp_pkg::RXD_OFF, d); `CHK(d, 32'h13c)
    u_rem.send(9'h042, 0, 0);
    wait_rx();
    rd(asp_pkg::RXD_OFF, d); `CHK(d, 32'h042)
    f = u_rem.frames;
    wr(asp_pkg::TXD_OFF, 32'h181);
    wait_fr(f + 1);
    `CHK(u_rem.got, 9'h181)
    rd(asp_pkg::IRQ_OFF, d); `CHK({d[5], d[0]}, 2'b11)
    close_out();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    tmo(1'b1);
  end
endmodule
